// [ipc_top.sv]
// Interrupt vectoring, power modes and the system control register
`timescale 1ns/1ns
`default_nettype none
`include "ipc_defs.svh"
module ipc_top
   import ipc_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic clk_en,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [7:0] grp0_pins,
   input wire logic [7:0] grp0_irq_en,
   input wire logic [13:0] grp1_pins,
   input wire logic [13:0] grp1_irq_en,
   input wire logic trap_req,
   input wire logic spi_irq,
   input wire logic tmra_irq,
   input wire logic tmrb_irq,
   input wire logic twi_irq,
   input wire logic cpu_irq_mask,
   input wire logic irq_ack,
   input wire logic wait_for_interrupt_instr,
   input wire logic halt_instr,
   input wire logic watchdog_enabled,
   input wire logic reset_event,
   output logic irq_take,
   output logic [15:0] irq_vector,
   output logic mask_clear,
   output logic cpu_run,
   output logic periph_run,
   output logic osc_run,
   output logic cpu_clk_tick,
   output logic watchdog_reset,
   output logic clock_out_pin,
   output logic clock_out_enable,
   output logic slow_select
);
   ipc_state_s q, d;

   // ----------------------------------------------------------------
   // Helper functions
   // ----------------------------------------------------------------
   function automatic logic ext_detect(input logic [1:0] pol, input logic now,
                                       input logic last);
      logic r;
      r = 1'b0;
      case (pol)
         `IPC_POL_LOW: r = !now;
         `IPC_POL_FALL: r = last && !now;
         `IPC_POL_RISE: r = !last && now;
         `IPC_POL_BOTH: r = last != now;
         default: r = 1'b0;
      endcase
      return r;
   endfunction

   function automatic logic [7:0] lane_merge(input logic [7:0] old, input logic [31:0] data,
                                             input logic [3:0] strb);
      logic [7:0] r;
      r = strb[0] ? data[7:0] : old;
      return r;
   endfunction

   // ----------------------------------------------------------------
   // Source combining
   // ----------------------------------------------------------------
   logic [1:0] ext_level;
   assign ext_level[0] = &(grp0_pins | ~grp0_irq_en);
   assign ext_level[1] = &(grp1_pins | ~grp1_irq_en);

   logic [1:0] ext_hit;
   logic [1:0] pol_fld [2];
   assign pol_fld[0] = {q.misc[`IPC_BIT_G0_HI], q.misc[`IPC_BIT_G0_LO]};
   assign pol_fld[1] = {q.misc[`IPC_BIT_G1_HI], q.misc[`IPC_BIT_G1_LO]};
   genvar gi;
   generate
      for (gi = 0; gi < 2; gi++) begin : g_ext
         assign ext_hit[gi] = ext_detect(pol_fld[gi], ext_level[gi], q.ext_last[gi]);
      end
   endgenerate

   // ----------------------------------------------------------------
   // Priority and vector
   // ----------------------------------------------------------------
   logic [15:0] sel_vec;
   logic sel_any;
   logic sel_ext0;
   logic sel_ext1;
   always_comb begin
      sel_any = 1'b1;
      sel_ext0 = 1'b0;
      sel_ext1 = 1'b0;
      if (trap_req) begin
         sel_vec = `IPC_VEC_TRAP;
      end else if (!cpu_irq_mask && q.ext_pend[0]) begin
         sel_vec = `IPC_VEC_EXT0;
         sel_ext0 = 1'b1;
      end else if (!cpu_irq_mask && q.ext_pend[1]) begin
         sel_vec = `IPC_VEC_EXT1;
         sel_ext1 = 1'b1;
      end else if (!cpu_irq_mask && spi_irq) begin
         sel_vec = `IPC_VEC_SPI;
      end else if (!cpu_irq_mask && tmra_irq) begin
         sel_vec = `IPC_VEC_TMRA;
      end else if (!cpu_irq_mask && tmrb_irq) begin
         sel_vec = `IPC_VEC_TMRB;
      end else if (!cpu_irq_mask && twi_irq) begin
         sel_vec = `IPC_VEC_TWI;
      end else begin
         sel_vec = `IPC_VEC_RESET;
         sel_any = 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   logic aw_go;
   logic [7:0] new_misc;
   logic [1:0] pol_clr;
   always_comb begin
      d = q;
      aw_go = 1'b0;
      new_misc = q.misc;
      pol_clr = 2'b00;
      // Clock prescaler
      d.cpu_tick = 1'b0;
      if (q.mode != IPC_HALT) begin
         if (q.div_cnt == 5'h00) begin
            d.div_cnt = q.misc[`IPC_BIT_SLOW] ? `IPC_DIV_SLOW : `IPC_DIV_NORMAL;
            d.cpu_clk = !q.cpu_clk;
            d.cpu_tick = !q.cpu_clk;
         end else begin
            d.div_cnt = q.div_cnt - 5'h01;
         end
      end
      // Register writes
      if (q.aw_full && q.w_full && !q.bvalid) begin
         d.aw_full = 1'b0;
         d.w_full = 1'b0;
         d.bvalid = 1'b1;
         d.bresp = `IPC_RESP_OKAY;
         if (q.aw_addr[7:2] == `IPC_OFF_MISC >> 2) begin
            aw_go = 1'b1;
            new_misc = lane_merge(q.misc, q.w_data, q.w_strb) & `IPC_MISC_RW_MASK;
         end else if (q.aw_addr[7:2] != `IPC_OFF_STATUS >> 2 &&
                      q.aw_addr[7:2] != `IPC_OFF_REQ >> 2) begin
            d.bresp = `IPC_RESP_SLVERR;
         end
      end
      if (aw_go) begin
         d.misc = new_misc;
         pol_clr[0] = new_misc[4:3] != q.misc[4:3];
         pol_clr[1] = new_misc[7:6] != q.misc[7:6];
      end
      if (s_axi_awvalid && s_axi_awready) begin
         d.aw_full = 1'b1;
         d.aw_addr = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
         d.w_full = 1'b1;
         d.w_data = s_axi_wdata;
         d.w_strb = s_axi_wstrb;
      end
      if (q.bvalid && s_axi_bready) begin
         d.bvalid = 1'b0;
      end
      // Register reads
      if (s_axi_arvalid && s_axi_arready) begin
         d.rvalid = 1'b1;
         d.rresp = `IPC_RESP_OKAY;
         d.rdata = 32'h0000_0000;
         case (s_axi_araddr[7:2])
            `IPC_OFF_MISC >> 2: d.rdata = {24'h00_0000, q.misc};
            `IPC_OFF_STATUS >> 2: d.rdata = {28'h000_0000, q.mode};
            `IPC_OFF_REQ >> 2: d.rdata = {28'h000_0000, q.ext_last, q.ext_pend};
            default: d.rresp = `IPC_RESP_SLVERR;
         endcase
      end else if (q.rvalid && s_axi_rready) begin
         d.rvalid = 1'b0;
      end
      // External request latches
      d.ext_last = ext_level;
      for (int i = 0; i < 2; i++) begin
         if (ext_hit[i]) begin
            d.ext_pend[i] = 1'b1;
         end else if (pol_clr[i] || (irq_take && (i == 0 ? sel_ext0 : sel_ext1))) begin
            d.ext_pend[i] = 1'b0;
         end
         if (pol_clr[i]) begin
            d.ext_pend[i] = 1'b0;
         end
      end
      // Power modes
      d.wdg_reset = 1'b0;
      case (q.mode)
         IPC_RUN: begin
            if (halt_instr && watchdog_enabled) begin
               d.wdg_reset = 1'b1;
            end else if (halt_instr) begin
               d.mode = IPC_HALT;
            end else if (wait_for_interrupt_instr) begin
               d.mode = IPC_WAIT;
            end
         end
         IPC_WAIT: begin
            if (reset_event || sel_any) begin
               d.mode = IPC_RUN;
            end
         end
         IPC_HALT: begin
            if (reset_event || ext_hit != 2'b00) begin
               d.mode = IPC_RESTART;
               d.wake_reset = reset_event;
               d.restart_cnt = `IPC_RESTART_CYCLES - 13'h0001;
            end
         end
         IPC_RESTART: begin
            if (q.cpu_tick) begin
               if (q.restart_cnt == 13'h0000) begin
                  d.mode = IPC_RUN;
                  d.wake_reset = 1'b0;
               end else begin
                  d.restart_cnt = q.restart_cnt - 13'h0001;
               end
            end
         end
         default: d.mode = IPC_RUN;
      endcase
      if (irq_take || q.wake_reset) begin
         d.vector = irq_take ? sel_vec : `IPC_VEC_RESET;
      end
   end

   // ----------------------------------------------------------------
   // State register
   // ----------------------------------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         q <= '0;
         q.mode <= IPC_RUN;
         q.misc <= `IPC_MISC_RESET;
         q.vector <= `IPC_VEC_RESET;
         q.ext_last <= 2'b11;
      end else if (clk_en) begin
         q <= d;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   assign s_axi_awready = !q.aw_full;
   assign s_axi_wready = !q.w_full;
   assign s_axi_bvalid = q.bvalid;
   assign s_axi_bresp = q.bresp;
   assign s_axi_arready = !q.rvalid;
   assign s_axi_rvalid = q.rvalid;
   assign s_axi_rdata = q.rdata;
   assign s_axi_rresp = q.rresp;
   assign irq_take = sel_any && irq_ack && (q.mode == IPC_RUN || q.mode == IPC_WAIT);
   assign irq_vector = q.vector;
   assign mask_clear = (q.mode == IPC_RUN) && !watchdog_enabled &&
                       (halt_instr || wait_for_interrupt_instr);
   assign cpu_run = q.mode == IPC_RUN;
   assign periph_run = q.mode != IPC_HALT && q.mode != IPC_RESTART;
   assign osc_run = q.mode != IPC_HALT;
   assign cpu_clk_tick = q.cpu_tick;
   assign watchdog_reset = q.wdg_reset;
   assign clock_out_enable = q.misc[`IPC_BIT_CKO];
   assign clock_out_pin = q.cpu_clk & q.misc[`IPC_BIT_CKO];
   assign slow_select = q.misc[`IPC_BIT_SLOW];
endmodule // ipc_top
`default_nettype wire

// [ipc_defs.svh]
// Constants for the interrupt and power control block
`ifndef IPC_DEFS_SVH
`define IPC_DEFS_SVH
`define IPC_OFF_MISC 8'h20
`define IPC_OFF_STATUS 8'h24
`define IPC_OFF_REQ 8'h28
`define IPC_MISC_RESET 8'h00
`define IPC_BIT_SLOW 0
`define IPC_BIT_G0_LO 3
`define IPC_BIT_G0_HI 4
`define IPC_BIT_CKO 5
`define IPC_BIT_G1_LO 6
`define IPC_BIT_G1_HI 7
`define IPC_MISC_RW_MASK 8'hf9
`define IPC_VEC_RESET 16'hfffe
`define IPC_VEC_TRAP 16'hfffc
`define IPC_VEC_EXT0 16'hfffa
`define IPC_VEC_EXT1 16'hfff8
`define IPC_VEC_SPI 16'hfff4
`define IPC_VEC_TMRA 16'hfff2
`define IPC_VEC_TMRB 16'hffee
`define IPC_VEC_TWI 16'hffe4
`define IPC_DIV_NORMAL 5'h00
`define IPC_DIV_SLOW 5'h0f
`define IPC_RESTART_CYCLES 13'h1000
`define IPC_POL_LOW 2'h0
`define IPC_POL_FALL 2'h2
`define IPC_POL_RISE 2'h1
`define IPC_POL_BOTH 2'h3
`define IPC_RESP_OKAY 2'h0
`define IPC_RESP_SLVERR 2'h2
`endif

// [ipc_pkg.sv]
// Types for the interrupt and power control block
package ipc_pkg;
   typedef enum logic [3:0] {
      IPC_RUN = 4'h1,
      IPC_WAIT = 4'h2,
      IPC_HALT = 4'h4,
      IPC_RESTART = 4'h8
   } ipc_mode_e;
   typedef struct packed {
      ipc_mode_e mode;
      logic [7:0] misc;
      logic [1:0] ext_pend;
      logic [1:0] ext_last;
      logic wake_reset;
      logic [12:0] restart_cnt;
      logic [4:0] div_cnt;
      logic cpu_clk;
      logic cpu_tick;
      logic wdg_reset;
      logic aw_full;
      logic [7:0] aw_addr;
      logic w_full;
      logic [31:0] w_data;
      logic [3:0] w_strb;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
      logic [15:0] vector;
   } ipc_state_s;
endpackage

// [ipc_cpu_model.sv]
// CPU side model: interrupt mask bit and acknowledge
`timescale 1ns/1ns
`default_nettype none
module ipc_cpu_model (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic ack_en,
   input wire logic irq_take,
   input wire logic mask_clear,
   output logic cpu_irq_mask,
   output logic irq_ack
);
   logic [3:0] iret_q;
   assign irq_ack = ack_en;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cpu_irq_mask <= 1'b0;
         iret_q <= 4'h0;
      end else if (irq_take) begin
         cpu_irq_mask <= 1'b1;
         iret_q <= 4'h8;
      end else if (mask_clear || iret_q == 4'h1) begin
         cpu_irq_mask <= 1'b0;
         iret_q <= 4'h0;
      end else if (iret_q != 4'h0) begin
         iret_q <= iret_q - 4'h1;
      end
   end
endmodule // ipc_cpu_model
`default_nettype wire

// [ipc_top_monitor.sv]
// Checker for the interrupt and power control block
`timescale 1ns/1ns
`default_nettype none
`include "ipc_defs.svh"
module ipc_top_monitor (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic halt_instr,
   input wire logic watchdog_enabled,
   input wire logic wait_for_interrupt_instr,
   input wire logic trap_req,
   input wire logic irq_take,
   input wire logic [15:0] irq_vector,
   input wire logic mask_clear,
   input wire logic cpu_run,
   input wire logic periph_run,
   input wire logic osc_run,
   input wire logic cpu_clk_tick,
   input wire logic watchdog_reset
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   sequence halt_go_s; halt_instr && cpu_run && !watchdog_enabled; endsequence
   sequence stopped_s; !osc_run && !periph_run && !cpu_run; endsequence
   chk_wdg_reset: assert property (halt_instr && cpu_run && watchdog_enabled |-> ##[1:2] watchdog_reset)
      else $error("no watchdog reset on halt");
   chk_halt_enter: assert property (halt_go_s |-> ##1 stopped_s)
      else $error("halt did not stop clocks");
   chk_halt_mask: assert property (halt_go_s |-> ##[0:1] mask_clear)
      else $error("halt entry kept mask");
   chk_wait_mask: assert property (wait_for_interrupt_instr && cpu_run |-> ##[0:1] mask_clear)
      else $error("wait entry kept mask");
   chk_wait_periph: assert property (wait_for_interrupt_instr && cpu_run && !irq_take |-> ##1 (!cpu_run && periph_run && osc_run))
      else $error("wait mode clocks wrong");
   chk_stop_notake: assert property (stopped_s |-> !irq_take)
      else $error("take while halted");
   chk_trap_vec: assert property (irq_take && trap_req |=> irq_vector == `IPC_VEC_TRAP)
      else $error("trap vector wrong");
   chk_tick_gap: assert property (cpu_clk_tick |=> !cpu_clk_tick [*1])
      else $error("cpu tick too close");
endmodule // ipc_top_monitor
bind ipc_top ipc_top_monitor u_ipc_top_monitor (.*);
`default_nettype wire

// [tb_top.sv]
// Testbench for the interrupt and power control block
`timescale 1ns/1ns
`default_nettype none
`include "ipc_defs.svh"
module tb_top;
   logic aclk = 1'b0, aresetn = 1'b0, clk_en = 1'b1, reset_event = 1'b0, ack_en = 1'b1;
   logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, grp0_irq_en = 8'hff, g0_q = 8'hff, wd;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, halt_instr = 1'b0, watchdog_enabled = 1'b0;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
   logic [3:0] s_axi_wstrb = 4'hf;
   logic [13:0] grp1_irq_en = 14'h3fff;
   logic [6:0] src = 7'h00;
   logic wait_for_interrupt_instr = 1'b0, s_axi_awready, s_axi_wready, s_axi_bvalid;
   logic s_axi_arready, s_axi_rvalid, irq_take, mask_clear, cpu_run, periph_run, osc_run;
   logic cpu_clk_tick, watchdog_reset, clock_out_pin, clock_out_enable, slow_select;
   logic cpu_irq_mask, irq_ack, cp;
   logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
   logic [15:0] irq_vector;
   wire [7:0] grp0_pins = src[5] ? 8'h00 : g0_q;
   wire [13:0] grp1_pins = src[4] ? 14'h0000 : 14'h3fff;
   wire trap_req = src[6];
   wire spi_irq = src[3], tmra_irq = src[2], tmrb_irq = src[1], twi_irq = src[0];
   int err_total = 0, comparisons = 0, cyc = 0, n, m;
   ipc_top u_ipc_top (.*);
   ipc_cpu_model u_ipc_cpu_model (.*);
   always #10 aclk = ~aclk;
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         err_total++;
         $display("[ERR] %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic wrap_up();
      $display("comparisons %0d errors %0d", comparisons, err_total);
      if (err_total == 0 && comparisons > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   always @(posedge aclk) begin
      cyc++;
      if (cyc == 60000) begin
         err_total++;
         wrap_up();
      end
   end
   task automatic axw(input logic [7:0] a, input logic [7:0] d);
      logic aw, w, b;
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= {24'h0, d};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(negedge aclk);
         aw = s_axi_awready & s_axi_awvalid;
         w = s_axi_wready & s_axi_wvalid;
         b = s_axi_bvalid;
         rsp = s_axi_bresp;
         @(posedge aclk);
         if (aw) s_axi_awvalid <= 1'b0;
         if (w) s_axi_wvalid <= 1'b0;
      end while (!b);
      s_axi_bready <= 1'b0;
   endtask
   task automatic axr(input logic [7:0] a);
      logic ar, v;
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(negedge aclk);
         ar = s_axi_arready & s_axi_arvalid;
         v = s_axi_rvalid;
         rd = s_axi_rdata;
         rsp = s_axi_rresp;
         @(posedge aclk);
         if (ar) s_axi_arvalid <= 1'b0;
      end while (!v);
      s_axi_rready <= 1'b0;
   endtask
   function automatic logic [15:0] vec(input int i);
      case (i)
         6: vec = `IPC_VEC_TRAP;
         5: vec = `IPC_VEC_EXT0;
         4: vec = `IPC_VEC_EXT1;
         3: vec = `IPC_VEC_SPI;
         2: vec = `IPC_VEC_TMRA;
         1: vec = `IPC_VEC_TMRB;
         default: vec = `IPC_VEC_TWI;
      endcase
   endfunction
   task automatic take(input int i);
      m = 0;
      do begin
         @(negedge aclk);
         m++;
      end while (!irq_take && m < 4000);
      @(posedge aclk);
      src[i] <= 1'b0;
      @(negedge aclk);
      chk("vector", irq_vector, vec(i));
   endtask
   task automatic pulse_wfi();
      @(posedge aclk);
      wait_for_interrupt_instr <= 1'b1;
      @(posedge aclk);
      wait_for_interrupt_instr <= 1'b0;
      @(negedge aclk);
   endtask
   initial begin
      void'($urandom(32'hf74664bf));
      repeat (8) @(posedge aclk);
      aresetn <= 1'b1;
      axr(8'h20);
      chk("misc reset", rd, 32'h0);
      repeat (4) begin
         wd = $urandom;
         axw(8'h20, wd | 8'h06);
         axr(8'h20);
         chk("misc rw", rd, {24'h0, wd & 8'hf9});
         chk("fields", {slow_select, clock_out_enable}, {wd[0], wd[5]});
      end
      axr(8'h40);
      chk("unmapped", rsp, `IPC_RESP_SLVERR);
      for (int s = 0; s < 2; s++) begin
         axw(8'h20, 8'h26 | s[7:0]);
         n = 0;
         m = 0;
         repeat (640) begin
            @(negedge aclk);
            n += cpu_clk_tick;
            m += clock_out_pin && !cp;
            cp = clock_out_pin;
         end
         chk("ticks", n >= (s ? 19 : 319) && n <= (s ? 21 : 321), 1);
         chk("clock out", m >= n - 1 && m <= n + 1, 1);
      end
      axw(8'h20, 8'h96);
      @(posedge aclk);
      src <= 7'h7f;
      for (int i = 6; i >= 0; i--) take(i);
      pulse_wfi();
      chk("wait run", {cpu_run, periph_run}, 2'b01);
      src[2] <= 1'b1;
      take(2);
      chk("wait exit", cpu_run, 1'b1);
      watchdog_enabled <= 1'b1;
      halt_instr <= 1'b1;
      @(posedge aclk);
      halt_instr <= 1'b0;
      n = 0;
      repeat (4) begin
         @(negedge aclk);
         n += watchdog_reset;
      end
      chk("wdg halt", n > 0 && osc_run, 1);
      @(posedge aclk);
      watchdog_enabled <= 1'b0;
      halt_instr <= 1'b1;
      @(posedge aclk);
      halt_instr <= 1'b0;
      @(negedge aclk);
      chk("halted", {osc_run, periph_run, cpu_run}, 3'b000);
      @(posedge aclk);
      src <= 7'h44;
      repeat (50) @(posedge aclk);
      chk("no wake", osc_run, 1'b0);
      src <= 7'h00;
      @(posedge aclk);
      src <= 7'h10;
      n = 0;
      do begin
         @(negedge aclk);
         n += cpu_clk_tick;
      end while (!cpu_run && cyc < 50000);
      chk("restart", n >= 4095 && n <= 4097, 1);
      take(4);
      ack_en <= 1'b0;
      g0_q <= 8'h00;
      axr(8'h28);
      chk("pending", rd[1:0], 2'b01);
      axw(8'h20, 8'h8e);
      axr(8'h28);
      chk("pol clear", rd[1:0], 2'b00);
      g0_q <= 8'hfe;
      axr(8'h28);
      chk("and mask", rd[1:0], 2'b00);
      g0_q <= 8'hff;
      axr(8'h28);
      chk("rise", rd[1:0], 2'b01);
      ack_en <= 1'b1;
      take(5);
      axr(8'h28);
      chk("served", rd[1:0], 2'b00);
      wrap_up();
   end
endmodule // tb_top
`default_nettype wire
